// *** cfg_decode_defines.svh ***
// Offsets, field positions, reset values and keys of the configuration decoder
`ifndef CFG_DECODE_DEFINES_SVH
`define CFG_DECODE_DEFINES_SVH

`define OFF_BOOT_CFG     5'h00
`define OFF_GEN_CFG      5'h04
`define OFF_SEQ_A        5'h08
`define OFF_SEQ_B        5'h0C
`define OFF_CONTROL      5'h10
`define OFF_STATUS       5'h14
`define OFF_PWM_KEY      5'h18

`define RST_BOOT_CFG     32'h0001_FFFF
`define RST_GEN_CFG      32'h0000_07FF
`define RST_SEQ          32'h0FFF_0FFF

`define BOOT_LVL_MSB     1
`define BOOT_LVL_LSB     0
`define BOOT_DIS_BIT     2
`define BOOT_WP_BIT      3
`define BOOT_LIM_MSB     16
`define BOOT_LIM_LSB     4
`define GEN_LVL_MSB      1
`define GEN_LVL_LSB      0
`define GEN_WP_BIT       2
`define CFG_WP_BIT       3
`define CFG_LVL_MSB      6
`define CFG_LVL_LSB      4
`define SWAP_DIS_BIT     7
`define ALT_DIS_BIT      8
`define TWO_SPEED_BIT    9
`define PWM_LOCK_BIT     10
`define DUAL_MODE_BIT    11
`define SEQ_MSB          11
`define SEQ_LSB          0
`define INV_MSB          27
`define INV_LSB          16
`define CTL_APPLY_BIT    0
`define CTL_ALT_REQ_BIT  8

`define SEQ_ALL_ONES     12'hFFF
// Key values are arbitrary
`define PWM_KEY_FIRST    32'h0000_ABCD
`define PWM_KEY_SECOND   32'h0000_4321

`endif

// *** cfg_decode_pkg.sv ***
// Types shared by the configuration decoder modules
package cfg_decode_pkg;

	typedef enum logic [1:0] {
		lvl_none     = 2'b00,
		lvl_standard = 2'b01,
		lvl_enhanced = 2'b10,
		lvl_high     = 2'b11
	} protect_level_type;

	typedef enum logic {
		ph_load = 1'b0,
		ph_run  = 1'b1
	} phase_type;

	typedef enum logic {
		key_idle  = 1'b0,
		key_first = 1'b1
	} key_stage_type;

	typedef struct packed {
		key_stage_type stage;
		logic          allowed;
	} key_state_type;

	typedef struct packed {
		phase_type         phase;
		logic              waitreq;
		logic [31:0]       rdata;
		logic [31:0]       boot_cfg;
		logic [31:0]       gen_cfg;
		logic [31:0]       seq_a;
		logic [31:0]       seq_b;
		logic              alt_req;
		logic              boot_present;
		logic [12:0]       last_page;
		logic              boot_wr;
		protect_level_type boot_lvl;
		logic              gen_wr;
		protect_level_type gen_lvl;
		logic              cfg_wr;
		protect_level_type cfg_lvl;
		logic              swap_en;
		logic              alt_allowed;
		logic              alt_en;
		logic              use_frc;
		logic              pwm_lock;
		logic [1:0]        seq_valid;
		logic              active_b;
	} main_state_type;

endpackage

// *** boot_sequence_select.sv ***
// Boot sequence validity check and active partition choice
`timescale 1ns/1ps
`include "cfg_decode_defines.svh"

module boot_sequence_select (
	input  wire logic [1:0][11:0] i_seq,
	input  wire logic [1:0][11:0] i_inv,
	input  wire logic             i_dual,
	output logic      [1:0]       o_valid,
	output logic                  o_active_b
);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_part
			assign o_valid[g] = ((i_seq[g] ^ i_inv[g]) == `SEQ_ALL_ONES);
		end
	endgenerate

	// An invalid number never wins; ties and double failure fall back to partition A
	always_comb begin
		o_active_b = 1'b0;
		if (i_dual) begin
			if (o_valid == 2'b10)
				o_active_b = 1'b1;
			else if (o_valid == 2'b11 && i_seq[1] < i_seq[0])
				o_active_b = 1'b1;
		end
	end

endmodule

// *** pwm_key_unlock.sv ***
// Key sequence gate for locked PWM register writes
`timescale 1ns/1ps
`include "cfg_decode_defines.svh"

module pwm_key_unlock (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_lock_enable,
	input  wire logic        i_key_write,
	input  wire logic [31:0] i_key_data,
	input  wire logic        i_consume,
	output logic             o_write_allowed
);

	cfg_decode_pkg::key_state_type s_r;
	cfg_decode_pkg::key_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!i_lock_enable) begin
			s_nxt.stage   = cfg_decode_pkg::key_idle;
			s_nxt.allowed = 1'b1;
		end else begin
			if (i_consume)
				s_nxt.allowed = 1'b0;
			// A key completed in the consume cycle still unlocks
			if (i_key_write) begin
				unique case (s_r.stage)
					cfg_decode_pkg::key_idle: begin
						if (i_key_data == `PWM_KEY_FIRST)
							s_nxt.stage = cfg_decode_pkg::key_first;
					end
					cfg_decode_pkg::key_first: begin
						s_nxt.stage = cfg_decode_pkg::key_idle;
						if (i_key_data == `PWM_KEY_SECOND)
							s_nxt.allowed = 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			s_r <= '{stage: cfg_decode_pkg::key_idle, allowed: 1'b0};
		else
			s_r <= s_nxt;
	end

	assign o_write_allowed = s_r.allowed;

	AST_PWM_FREE_WHEN_UNLOCKED: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!i_lock_enable |=> o_write_allowed)
		else $error("PWM writes not free with lock disabled");

endmodule

// *** config_bits_protection_decode.sv ***
// Configuration bit decoder with protection, partition and start-up controls
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "cfg_decode_defines.svh"

// What this block does
// - Decode boot protection level field
// - Boot segment disable bit removes boot segment
// - Boot write protect bit low blocks writes
// - Boot page limit is inverted last page
// - Decode general segment protection level field
// - General write protect bit low blocks writes
// - Config write protect bit low blocks writes
// - Decode three-bit config protection level field
// - Swap disable bit high forbids swap instruction
// - Lower valid boot sequence picks active partition
// - Inverse not complement makes sequence invalid
// - Alt vector table needs bit clear plus request
// - Alt vector table needs a boot segment
// - Two-speed start runs fast RC until ready
// - PWM lock requires key sequence before writes
module config_bits_protection_decode (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic [4:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic [31:0] i_writedata,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	input  wire logic        i_osc_ready,
	input  wire logic        i_pwm_reg_write,
	output logic             o_boot_segment_present,
	output logic      [12:0] o_boot_last_page,
	output logic             o_boot_writable,
	output logic      [1:0]  o_boot_protect,
	output logic             o_general_writable,
	output logic      [1:0]  o_general_protect,
	output logic             o_config_writable,
	output logic      [1:0]  o_config_protect,
	output logic             o_swap_instr_enable,
	output logic      [1:0]  o_sequence_valid,
	output logic             o_active_partition_b,
	output logic             o_alt_vector_enable,
	output logic             o_use_fast_rc,
	output logic             o_pwm_lock_active,
	output logic             o_pwm_write_allowed
);

	cfg_decode_pkg::main_state_type s_r;
	cfg_decode_pkg::main_state_type s_nxt;

	logic [31:0] rd_word;
	logic        bus_write;
	logic        key_write;
	logic [1:0]  seq_valid;
	logic        active_b;
	logic        pwm_allowed;

	function automatic cfg_decode_pkg::protect_level_type level_of_two(input logic [1:0] f);
		if (f == 2'b11)
			return cfg_decode_pkg::lvl_none;
		else if (f == 2'b10)
			return cfg_decode_pkg::lvl_standard;
		else
			return cfg_decode_pkg::lvl_high;
	endfunction

	function automatic cfg_decode_pkg::protect_level_type level_of_three(input logic [2:0] f);
		if (f == 3'b111)
			return cfg_decode_pkg::lvl_none;
		else if (f == 3'b110)
			return cfg_decode_pkg::lvl_standard;
		else if (f[2])
			return cfg_decode_pkg::lvl_enhanced;
		else
			return cfg_decode_pkg::lvl_high;
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	boot_sequence_select u_seq (
		.i_seq      ({s_r.seq_b[`SEQ_MSB:`SEQ_LSB], s_r.seq_a[`SEQ_MSB:`SEQ_LSB]}),
		.i_inv      ({s_r.seq_b[`INV_MSB:`INV_LSB], s_r.seq_a[`INV_MSB:`INV_LSB]}),
		.i_dual     (s_r.gen_cfg[`DUAL_MODE_BIT]),
		.o_valid    (seq_valid),
		.o_active_b (active_b)
	);

	assign bus_write = i_write && !s_r.waitreq;
	assign key_write = bus_write && (i_address == `OFF_PWM_KEY);

	pwm_key_unlock u_key (
		.i_clk           (i_clk),
		.i_rstn          (i_rstn),
		// A load withdraws any unlock left over from an earlier image
		.i_lock_enable   (s_r.pwm_lock || (s_r.phase == cfg_decode_pkg::ph_load)),
		.i_key_write     (key_write),
		.i_key_data      (i_writedata),
		.i_consume       (i_pwm_reg_write || (s_r.phase == cfg_decode_pkg::ph_load)),
		.o_write_allowed (pwm_allowed)
	);

	always_comb begin
		unique case (i_address)
			`OFF_BOOT_CFG: rd_word = s_r.boot_cfg;
			`OFF_GEN_CFG:  rd_word = s_r.gen_cfg;
			`OFF_SEQ_A:    rd_word = s_r.seq_a;
			`OFF_SEQ_B:    rd_word = s_r.seq_b;
			`OFF_CONTROL:  rd_word = {23'h00_0000, s_r.alt_req, 8'h00};
			`OFF_STATUS:   rd_word = {s_r.last_page, s_r.phase, s_r.pwm_lock, pwm_allowed, s_r.use_frc,
				s_r.alt_en, s_r.seq_valid, s_r.active_b, s_r.swap_en, s_r.cfg_wr, s_r.gen_wr,
				s_r.boot_wr, s_r.boot_present, s_r.cfg_lvl, s_r.gen_lvl, s_r.boot_lvl};
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// One wait cycle per access; read data stand in the release cycle
		s_nxt.waitreq = !(s_r.waitreq && (i_read || i_write));
		if (s_r.waitreq && i_read)
			s_nxt.rdata = rd_word;
		if (bus_write) begin
			unique case (i_address)
				`OFF_BOOT_CFG: s_nxt.boot_cfg = merge_bytes(s_r.boot_cfg, i_writedata, i_byteenable);
				`OFF_GEN_CFG:  s_nxt.gen_cfg = merge_bytes(s_r.gen_cfg, i_writedata, i_byteenable);
				`OFF_SEQ_A:    s_nxt.seq_a = merge_bytes(s_r.seq_a, i_writedata, i_byteenable);
				`OFF_SEQ_B:    s_nxt.seq_b = merge_bytes(s_r.seq_b, i_writedata, i_byteenable);
				`OFF_CONTROL: begin
					if (i_byteenable[1])
						s_nxt.alt_req = i_writedata[`CTL_ALT_REQ_BIT];
					// Apply acts as a device reset for the decoded outputs
					if (i_byteenable[0] && i_writedata[`CTL_APPLY_BIT])
						s_nxt.phase = cfg_decode_pkg::ph_load;
				end
				default: ;
			endcase
		end

		if (s_r.phase == cfg_decode_pkg::ph_load) begin
			// Only this cycle copies the image; later edits wait for the next apply and are lost on reset
			s_nxt.phase        = cfg_decode_pkg::ph_run;
			s_nxt.boot_lvl     = level_of_two(s_r.boot_cfg[`BOOT_LVL_MSB:`BOOT_LVL_LSB]);
			s_nxt.boot_present = !s_r.boot_cfg[`BOOT_DIS_BIT];
			s_nxt.boot_wr      = s_r.boot_cfg[`BOOT_WP_BIT];
			s_nxt.last_page    = ~s_r.boot_cfg[`BOOT_LIM_MSB:`BOOT_LIM_LSB];
			s_nxt.gen_lvl      = level_of_two(s_r.gen_cfg[`GEN_LVL_MSB:`GEN_LVL_LSB]);
			s_nxt.gen_wr       = s_r.gen_cfg[`GEN_WP_BIT];
			s_nxt.cfg_wr       = s_r.gen_cfg[`CFG_WP_BIT];
			s_nxt.cfg_lvl      = level_of_three(s_r.gen_cfg[`CFG_LVL_MSB:`CFG_LVL_LSB]);
			s_nxt.swap_en      = !s_r.gen_cfg[`SWAP_DIS_BIT];
			s_nxt.seq_valid    = seq_valid;
			s_nxt.active_b     = active_b;
			s_nxt.alt_allowed  = !s_r.gen_cfg[`ALT_DIS_BIT] && !s_r.boot_cfg[`BOOT_DIS_BIT];
			s_nxt.use_frc      = s_r.gen_cfg[`TWO_SPEED_BIT];
			s_nxt.pwm_lock     = s_r.gen_cfg[`PWM_LOCK_BIT];
		end else if (s_r.use_frc && i_osc_ready) begin
			s_nxt.use_frc = 1'b0;
		end

		// The request bit is live, the permission is the latched one
		s_nxt.alt_en = s_nxt.alt_allowed && s_r.alt_req;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			s_r              <= '0;
			s_r.phase        <= cfg_decode_pkg::ph_load;
			s_r.waitreq      <= 1'b1;
			s_r.boot_cfg     <= `RST_BOOT_CFG;
			s_r.gen_cfg      <= `RST_GEN_CFG;
			s_r.seq_a        <= `RST_SEQ;
			s_r.seq_b        <= `RST_SEQ;
			s_r.boot_lvl     <= cfg_decode_pkg::lvl_high;
			s_r.gen_lvl      <= cfg_decode_pkg::lvl_high;
			s_r.cfg_lvl      <= cfg_decode_pkg::lvl_high;
			s_r.pwm_lock     <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_readdata             = s_r.rdata;
	assign o_waitrequest          = s_r.waitreq;
	assign o_boot_segment_present = s_r.boot_present;
	assign o_boot_last_page       = s_r.last_page;
	assign o_boot_writable        = s_r.boot_wr;
	assign o_boot_protect         = s_r.boot_lvl;
	assign o_general_writable     = s_r.gen_wr;
	assign o_general_protect      = s_r.gen_lvl;
	assign o_config_writable      = s_r.cfg_wr;
	assign o_config_protect       = s_r.cfg_lvl;
	assign o_swap_instr_enable    = s_r.swap_en;
	assign o_sequence_valid       = s_r.seq_valid;
	assign o_active_partition_b   = s_r.active_b;
	assign o_alt_vector_enable    = s_r.alt_en;
	assign o_use_fast_rc          = s_r.use_frc;
	assign o_pwm_lock_active      = s_r.pwm_lock;
	assign o_pwm_write_allowed    = pwm_allowed;

	AST_BOOT_HIGH_SECURITY: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_load && !s_r.boot_cfg[`BOOT_LVL_MSB])
		|=> o_boot_protect == cfg_decode_pkg::lvl_high)
		else $error("Boot level not high for 0x field");

	AST_NO_BOOT_SEGMENT: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_load && s_r.boot_cfg[`BOOT_DIS_BIT])
		|=> !o_boot_segment_present ##1 !o_alt_vector_enable)
		else $error("Boot segment present while disabled");

	AST_BOOT_WRITE_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_load && !s_r.boot_cfg[`BOOT_WP_BIT]) |=> !o_boot_writable)
		else $error("Boot segment writable while protected");

	AST_LAST_PAGE_INVERTED: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_load)
		|=> o_boot_last_page == ~$past(s_r.boot_cfg[`BOOT_LIM_MSB:`BOOT_LIM_LSB]))
		else $error("Boot last page not inverted limit");

	AST_CONFIG_STANDARD: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_load && s_r.gen_cfg[`CFG_LVL_MSB:`CFG_LVL_LSB] == 3'b110)
		|=> o_config_protect == cfg_decode_pkg::lvl_standard)
		else $error("Config level not standard for 110");

	AST_SEQ_INVALID: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_load
		&& (s_r.seq_a[`SEQ_MSB:`SEQ_LSB] ^ s_r.seq_a[`INV_MSB:`INV_LSB]) != `SEQ_ALL_ONES)
		|=> !o_sequence_valid[0])
		else $error("Partition A sequence valid without complement");

	AST_ALT_NEEDS_BOOT: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_alt_vector_enable |-> o_boot_segment_present && $past(s_r.alt_req))
		else $error("Alt vector table without boot segment or request");

	AST_HELD_AFTER_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_run) |=> $stable(o_boot_last_page) && $stable(o_config_protect))
		else $error("Decoded fields changed outside load");

	AST_FAST_RC_SWITCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(s_r.phase == cfg_decode_pkg::ph_run && o_use_fast_rc && i_osc_ready) |=> !o_use_fast_rc)
		else $error("No switch off fast RC once source ready");

endmodule

// *** cfg_image_programmer.sv ***
// Programmer model: writes configuration images through the register bus
`timescale 1ns/1ps
`include "cfg_decode_defines.svh"

module cfg_image_programmer (
	input  wire logic        i_clk,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	output logic      [4:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [3:0]  o_byteenable,
	output logic      [31:0] o_writedata
);
	initial begin
		o_address = 5'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_byteenable = 4'hF;
		o_writedata = 32'h0000_0000;
	end

	// Waitrequest is registered, so the level seen before an edge is what that edge samples
	task automatic wait_accept(output logic [31:0] d);
		do @(negedge i_clk); while (i_waitrequest !== 1'b0);
		d = i_readdata;
		@(posedge i_clk);
	endtask

	task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] unused;
		@(posedge i_clk);
		o_address <= a;
		o_writedata <= d;
		o_write <= 1'b1;
		wait_accept(unused);
		o_write <= 1'b0;
	endtask

	task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_address <= a;
		o_read <= 1'b1;
		wait_accept(d);
		o_read <= 1'b0;
	endtask

	// Corrupts the inverse field only when a scenario asks for it
	task automatic program_seq(input logic [4:0] a, input logic [11:0] s, input logic bad, output logic [31:0] w);
		w = {4'h0, ~s ^ {11'h000, bad}, 4'h0, s};
		bus_write(a, w);
	endtask
endmodule

// *** config_bits_protection_decode_test.sv ***
// Self-checking bench for the configuration bit decoder
`timescale 1ns/1ps
`include "cfg_decode_defines.svh"

module config_bits_protection_decode_test;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        osc_ready = 1'b0;
	logic        pwm_wr = 1'b0;
	logic [4:0]  address;
	logic        bus_rd;
	logic        bus_wr;
	logic [3:0]  be;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic        present;
	logic [12:0] last_page;
	logic        boot_wr;
	logic [1:0]  boot_prot;
	logic        gen_wr;
	logic [1:0]  gen_prot;
	logic        cfg_wr;
	logic [1:0]  cfg_prot;
	logic        swap_en;
	logic [1:0]  valid;
	logic        act_b;
	logic        alt_en;
	logic        fast_rc;
	logic        pwm_lock;
	logic        pwm_ok;
	int          miscompares = 0;
	int          n_tests = 0;
	int          seed = 30260;

	always #25 clk = ~clk;

	config_bits_protection_decode uut (
		.i_clk(clk), .i_rstn(rstn), .i_address(address), .i_read(bus_rd), .i_write(bus_wr),
		.i_byteenable(be), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
		.i_osc_ready(osc_ready), .i_pwm_reg_write(pwm_wr), .o_boot_segment_present(present),
		.o_boot_last_page(last_page), .o_boot_writable(boot_wr), .o_boot_protect(boot_prot),
		.o_general_writable(gen_wr), .o_general_protect(gen_prot), .o_config_writable(cfg_wr),
		.o_config_protect(cfg_prot), .o_swap_instr_enable(swap_en), .o_sequence_valid(valid),
		.o_active_partition_b(act_b), .o_alt_vector_enable(alt_en), .o_use_fast_rc(fast_rc),
		.o_pwm_lock_active(pwm_lock), .o_pwm_write_allowed(pwm_ok)
	);

	cfg_image_programmer prog (
		.i_clk(clk), .i_waitrequest(waitreq), .i_readdata(rdata), .o_address(address),
		.o_read(bus_rd), .o_write(bus_wr), .o_byteenable(be), .o_writedata(wdata)
	);

	function automatic logic [1:0] lvl2(input logic [1:0] f);
		return f == 2'b11 ? cfg_decode_pkg::lvl_none : f == 2'b10 ? cfg_decode_pkg::lvl_standard
			: cfg_decode_pkg::lvl_high;
	endfunction

	function automatic logic [1:0] lvl3(input logic [2:0] f);
		return f == 3'b111 ? cfg_decode_pkg::lvl_none : f == 3'b110 ? cfg_decode_pkg::lvl_standard
			: f[2] ? cfg_decode_pkg::lvl_enhanced : cfg_decode_pkg::lvl_high;
	endfunction

	function automatic logic ok_seq(input logic [31:0] w);
		return (w[11:0] ^ w[27:16]) == 12'hFFF;
	endfunction

	function automatic logic exp_act(input logic [31:0] g, input logic [31:0] wa, input logic [31:0] wb);
		if (!g[11])
			return 1'b0;
		return ok_seq(wb) && (!ok_seq(wa) || wb[11:0] < wa[11:0]);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t readback got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic check_decode(input logic [31:0] b, g, wa, wb, input logic c8);
		chk(16'(boot_prot), 16'(lvl2(b[1:0])), "boot lvl");
		chk(16'(present), 16'(!b[2]), "present");
		chk(16'(boot_wr), 16'(b[3]), "boot wr");
		chk(16'(last_page), 16'(b[16:4] ^ 13'h1FFF), "last page");
		chk(16'(gen_prot), 16'(lvl2(g[1:0])), "gen lvl");
		chk(16'(gen_wr), 16'(g[2]), "gen wr");
		chk(16'(cfg_wr), 16'(g[3]), "cfg wr");
		chk(16'(cfg_prot), 16'(lvl3(g[6:4])), "cfg lvl");
		chk(16'(swap_en), 16'(!g[7]), "swap");
		chk(16'(act_b), 16'(exp_act(g, wa, wb)), "active");
		if (g[11])
			chk(16'(valid), 16'({ok_seq(wb), ok_seq(wa)}), "valid");
		chk(16'(alt_en), 16'(!g[8] && !b[2] && c8), "alt");
		chk(16'(fast_rc), 16'(g[9]), "fast rc");
		chk(16'({pwm_lock, pwm_ok}), 16'({g[10], !g[10]}), "pwm");
	endtask

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		logic [31:0] b, g, a, bb, wa, wb, rd;
		logic        c8;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		settle(3);
		check_decode(`RST_BOOT_CFG, `RST_GEN_CFG, `RST_SEQ, `RST_SEQ, 1'b0);
		prog.bus_read(`OFF_BOOT_CFG, rd);
		chk_rd(rd, `RST_BOOT_CFG);
		prog.bus_read(`OFF_SEQ_B, rd);
		chk_rd(rd, `RST_SEQ);
		prog.bus_read(5'h1C, rd);
		chk_rd(rd, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			b = $random(seed) & 32'h0001_FFFF;
			g = $random(seed) & 32'h0000_0FFF;
			a = $random(seed);
			bb = (i % 3 == 1) ? a : $random(seed);
			c8 = a[31];
			// Walk every level code instead of hoping random draws hit them
			b[1:0] = i[1:0];
			g[1:0] = ~i[1:0];
			g[6:4] = i[2:0];
			if (i == 0) begin
				b[2] = 1'b0;
				g[8] = 1'b0;
				c8 = 1'b1;
			end
			if (i == 1)
				b[16:4] = 13'h0000;
			if (i < 2)
				g[11] = 1'b1;
			prog.bus_write(`OFF_BOOT_CFG, b);
			prog.bus_write(`OFF_GEN_CFG, g);
			prog.program_seq(`OFF_SEQ_A, a[11:0], i % 4 == 2, wa);
			prog.program_seq(`OFF_SEQ_B, bb[11:0], i % 5 == 3, wb);
			prog.bus_read(`OFF_SEQ_A, rd);
			chk_rd(rd, wa);
			prog.bus_write(`OFF_CONTROL, {23'h00_0000, c8, 8'h01});
			settle(3);
			check_decode(b, g, wa, wb, c8);
			if (g[9]) begin
				@(posedge clk);
				osc_ready <= 1'b1;
				settle(2);
				chk(16'(fast_rc), 16'h0000, "switch");
				@(posedge clk);
				osc_ready <= 1'b0;
			end
			if (g[10]) begin
				prog.bus_write(`OFF_PWM_KEY, `PWM_KEY_FIRST);
				prog.bus_write(`OFF_PWM_KEY, 32'h0000_0000);
				settle(2);
				chk(16'(pwm_ok), 16'h0000, "bad key");
				prog.bus_write(`OFF_PWM_KEY, `PWM_KEY_FIRST);
				prog.bus_write(`OFF_PWM_KEY, `PWM_KEY_SECOND);
				settle(2);
				chk(16'(pwm_ok), 16'h0001, "unlock");
				@(posedge clk);
				pwm_wr <= 1'b1;
				@(posedge clk);
				pwm_wr <= 1'b0;
				settle(2);
				chk(16'(pwm_ok), 16'h0000, "consume");
			end
			prog.bus_write(`OFF_BOOT_CFG, b ^ 32'h0000_0004);
			settle(2);
			chk(16'(present), 16'(!b[2]), "held");
			prog.bus_read(`OFF_BOOT_CFG, rd);
			chk_rd(rd, b ^ 32'h0000_0004);
			$display("test %0d done", i);
		end
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
